/* File: tb/swc_osc_model.sv */
// Main crystal oscillator model with a short start-up delay
`timescale 1ns/10ps
`default_nettype none
module swc_osc_model (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Oscillator
	input  wire logic osc_enable_q,
	output var  logic osc_running
);
	logic [1:0] warm_q;
	// Crystal only: stops one cycle after disable, runs two cycles after enable
	always_ff @(posedge aclk) begin
		if (!aresetn)
			warm_q <= 2'h3;
		else if (!osc_enable_q)
			warm_q <= 2'h0;
		else
			warm_q <= {warm_q[0], 1'b1};
	end
	assign osc_running = warm_q[1];
endmodule : swc_osc_model
`default_nettype wire

/* File: tb/swc_properties.sv */
// Checker: port-level relations of the standby wake controller
`timescale 1ns/10ps
`default_nettype none
module swc_properties (
	// Clock and reset
	input wire logic                 aclk,
	input wire logic                 aresetn,
	// Core and interrupt controller
	input wire logic                 stop_exec,
	input wire logic                 reset_req,
	input wire swc_pkg::swc_irq_s    irq_in,
	// Oscillator and core control
	input wire logic                 osc_enable_q,
	input wire logic                 oscillator_output_pin_pullup_q,
	input wire logic                 subsys_clk_en_q,
	input wire logic                 core_clk_en_q,
	input wire logic                 core_reset_q,
	input wire logic                 wake_service_q,
	input wire logic                 wake_next_q,
	input wire logic                 port_latch_hold_q,
	input wire swc_pkg::swc_periph_s periph_run_q
);
	wire logic unm;
	wire logic pulse;
	assign unm = |(irq_in.req & ~irq_in.mask);
	assign pulse = core_reset_q | wake_service_q | wake_next_q;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	//////////////////////////////////////////////////////////////////////////
	// Stop request as seen in run, and the minimum gated stretch after it
	sequence s_stop_req;
		core_clk_en_q && stop_exec;
	endsequence
	sequence s_gated;
		!core_clk_en_q [*4];
	endsequence
	//////////////////////////////////////////////////////////////////////////
	a_stop_entry: assert property (s_stop_req ##0 !unm |=> oscillator_output_pin_pullup_q)
		else $error("stop mode not entered");
	a_stop_pending: assert property (s_stop_req ##0 unm |=> !oscillator_output_pin_pullup_q && osc_enable_q)
		else $error("pending request did not bypass stop");
	a_pullup_osc_off: assert property (oscillator_output_pin_pullup_q |-> !osc_enable_q && !core_clk_en_q)
		else $error("pull-up without oscillator stop");
	a_subclk_always: assert property (subsys_clk_en_q)
		else $error("subsystem clock stopped");
	a_latch_hold: assert property (port_latch_hold_q == !core_clk_en_q)
		else $error("port latch hold wrong");
	a_stop_periph: assert property (oscillator_output_pin_pullup_q |-> (periph_run_q & 12'h9ef) == 12'h001)
		else $error("peripheral gating wrong in stop");
	a_stop_hold: assert property (oscillator_output_pin_pullup_q && !unm && !reset_req |=> oscillator_output_pin_pullup_q)
		else $error("stop left without a wake source");
	a_stab_wait: assert property ($fell(oscillator_output_pin_pullup_q) |-> s_gated)
		else $error("core ungated before stabilization");
	a_pulse_single: assert property (pulse |-> core_clk_en_q ##1 !pulse)
		else $error("wake pulse malformed");
endmodule : swc_properties
bind swc_top swc_properties u_props (.aclk, .aresetn, .stop_exec, .reset_req, .irq_in, .osc_enable_q,
	.oscillator_output_pin_pullup_q, .subsys_clk_en_q, .core_clk_en_q, .core_reset_q, .wake_service_q,
	.wake_next_q, .port_latch_hold_q, .periph_run_q);
`default_nettype wire

/* File: tb/tb.sv */
// Testbench: register access, halt and stop wake sequences
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic                       aclk, aresetn, halt_exec, stop_exec, reset_req, osc_running;
	swc_pkg::swc_irq_s          irq_in;
	logic                       osc_enable_q, oscillator_output_pin_pullup_q, subsys_clk_en_q;
	logic                       core_clk_en_q, core_reset_q, wake_service_q, wake_next_q, port_latch_hold_q;
	swc_pkg::swc_periph_s       periph_run_q;
	logic [swc_pkg::ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0]                s_axi_wdata, s_axi_rdata;
	logic [3:0]                 s_axi_wstrb;
	logic [1:0]                 s_axi_bresp, s_axi_rresp;
	logic                       s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic                       s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int                         failures, comparisons;
	logic [11:0]                stop_periph;
	// Short stabilization counts keep the run brief
	swc_top #(.STAB_CNT_0(4), .STAB_CNT_1(8), .STAB_CNT_2(12), .STAB_CNT_3(16), .STAB_CNT_4(20)) u_dut (
		.aclk, .aresetn, .halt_exec, .stop_exec, .reset_req, .irq_in, .osc_running, .osc_enable_q,
		.oscillator_output_pin_pullup_q, .subsys_clk_en_q, .core_clk_en_q, .core_reset_q, .wake_service_q,
		.wake_next_q, .port_latch_hold_q, .periph_run_q, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);
	swc_osc_model u_osc (.aclk, .aresetn, .osc_enable_q, .osc_running);
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	//////////////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic tmo(input logic ok);
		chk(32'(ok), 32'h0000_0001);
		if (ok !== 1'b1)
			end_of_test();
	endtask : tmo
	// Request flags: bit 3 is the only source that the mask can open
	function automatic swc_pkg::swc_irq_s mk(input logic m, input logic p, input logic e, input logic i,
			input logic n);
		return {8'hff, m ? 8'hff : 8'hf7, p ? 8'h08 : 8'hf7, e, i, n};
	endfunction : mk
	//////////////////////////////////////////////////////////////////////////
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		int n;
		logic aw, w, b;
		logic [1:0] r;
		b = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 40 && b !== 1'b1; n++) begin
			@(negedge aclk);
			aw = s_axi_awready;
			w = s_axi_wready;
			b = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (aw === 1'b1) s_axi_awvalid <= 1'b0;
			if (w === 1'b1) s_axi_wvalid <= 1'b0;
			if (b === 1'b1) s_axi_bready <= 1'b0;
		end
		tmo(b);
		chk(32'(r), 32'(er));
	endtask : axw
	task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		logic ar, v;
		logic [31:0] d;
		logic [1:0] r;
		v = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 40 && v !== 1'b1; n++) begin
			@(negedge aclk);
			ar = s_axi_arready;
			v = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ar === 1'b1) s_axi_arvalid <= 1'b0;
			if (v === 1'b1) s_axi_rready <= 1'b0;
		end
		tmo(v);
		chk(d, ed);
		chk(32'(r), 32'(er));
	endtask : axr
	// Enter halt or stop, present a wake source, then judge the kind and delay of the wake pulse
	task automatic wake(input logic stp, input logic pend, input logic rst, input swc_pkg::swc_irq_s irq,
			input logic [1:0] kind, input int lo, input int hi);
		int n;
		logic [1:0] got;
		got = 2'h0;
		@(posedge aclk);
		halt_exec <= !stp;
		stop_exec <= stp;
		if (pend) irq_in <= irq;
		@(posedge aclk);
		halt_exec <= 1'b0;
		stop_exec <= 1'b0;
		irq_in <= irq;
		reset_req <= rst;
		for (n = 0; n < 40 && got === 2'h0; n++) begin
			@(posedge aclk);
			#1;
			got = {core_reset_q | wake_next_q, core_reset_q | wake_service_q};
		end
		chk(32'(got), 32'(kind));
		chk(32'(n - 1 >= lo && n - 1 <= hi), 32'h0000_0001);
		if (kind == 2'h0 && stp) chk(32'(periph_run_q), 32'(stop_periph));
		@(posedge aclk);
		irq_in <= '0;
		reset_req <= 1'b0;
	endtask : wake
	//////////////////////////////////////////////////////////////////////////
	initial begin
		{aresetn, halt_exec, stop_exec, reset_req, irq_in, s_axi_awaddr, s_axi_araddr} = '0;
		{s_axi_wdata, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		failures = 0;
		comparisons = 0;
		stop_periph = 12'h611;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		axr(swc_pkg::ADDR_CTRL, 32'h0000_0004, swc_pkg::RESP_OKAY);
		axw(swc_pkg::ADDR_CTRL, 32'h0000_0005, 4'hf, swc_pkg::RESP_OKAY);
		axr(swc_pkg::ADDR_CTRL, 32'h0000_0004, swc_pkg::RESP_OKAY);
		axw(swc_pkg::ADDR_CTRL, 32'h0000_0038, 4'h0, swc_pkg::RESP_OKAY);
		axr(swc_pkg::ADDR_CTRL, 32'h0000_0004, swc_pkg::RESP_OKAY);
		axw(swc_pkg::ADDR_CTRL, 32'h0000_0038, 4'hf, swc_pkg::RESP_OKAY);
		axr(swc_pkg::ADDR_CTRL, 32'h0000_0038, swc_pkg::RESP_OKAY);
		axw(8'h10, 32'h0000_0001, 4'hf, swc_pkg::RESP_SLVERR);
		axr(8'h10, 32'h0000_0000, swc_pkg::RESP_SLVERR);
		wake(1'b0, 1'b0, 1'b0, mk(0, 0, 0, 0, 0), swc_pkg::CAUSE_NEXT, 2, 3);
		wake(1'b0, 1'b0, 1'b0, mk(0, 0, 1, 0, 0), swc_pkg::CAUSE_SERVICE, 8, 9);
		wake(1'b0, 1'b0, 1'b0, mk(0, 1, 0, 1, 0), swc_pkg::CAUSE_NEXT, 2, 3);
		wake(1'b0, 1'b0, 1'b0, mk(0, 1, 1, 0, 0), swc_pkg::CAUSE_NEXT, 2, 3);
		wake(1'b0, 1'b0, 1'b0, mk(0, 1, 1, 1, 0), swc_pkg::CAUSE_SERVICE, 8, 9);
		wake(1'b0, 1'b0, 1'b0, mk(1, 0, 1, 1, 0), swc_pkg::CAUSE_NONE, 39, 39);
		wake(1'b0, 1'b0, 1'b1, '0, swc_pkg::CAUSE_RESET, 0, 2);
		wake(1'b0, 1'b0, 1'b0, mk(1, 0, 0, 0, 1), swc_pkg::CAUSE_SERVICE, 8, 9);
		wake(1'b1, 1'b0, 1'b0, mk(0, 0, 1, 0, 0), swc_pkg::CAUSE_SERVICE, 4, 12);
		wake(1'b1, 1'b0, 1'b0, mk(0, 1, 1, 0, 0), swc_pkg::CAUSE_NEXT, 4, 12);
		wake(1'b1, 1'b1, 1'b0, mk(0, 0, 0, 0, 0), swc_pkg::CAUSE_NEXT, 3, 12);
		wake(1'b1, 1'b0, 1'b0, mk(1, 0, 1, 1, 1), swc_pkg::CAUSE_NONE, 39, 39);
		wake(1'b1, 1'b0, 1'b1, '0, swc_pkg::CAUSE_RESET, 20, 28);
		axr(swc_pkg::ADDR_STATUS, 32'h0000_0038, swc_pkg::RESP_OKAY);
		// Only timer b on its external input: timer a and the serial port must sleep in stop
		axw(swc_pkg::ADDR_CTRL, 32'h0000_0010, 4'hf, swc_pkg::RESP_OKAY);
		stop_periph = 12'h201;
		wake(1'b1, 1'b0, 1'b0, mk(1, 0, 1, 1, 1), swc_pkg::CAUSE_NONE, 39, 39);
		end_of_test();
	end
endmodule : tb
`default_nettype wire

/* File: verilog/swc_pkg.sv */
// Package: constants, register map and carrier types of the standby wake controller
`default_nettype none
package swc_pkg;

	//////////////////////////////////////////////////////////////////////////
	// Sizes
	localparam int          IRQ_N      = 8;
	localparam int          ADDR_W     = 8;
	localparam int          STAB_CNT_W = 18;

	//////////////////////////////////////////////////////////////////////////
	// Register map
	localparam logic [7:0]  ADDR_CTRL   = 8'h00;
	localparam logic [7:0]  ADDR_STATUS = 8'h04;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// Control word fields
	localparam int          CTRL_STAB_LSB = 0;
	localparam int          CTRL_STAB_MSB = 2;
	localparam int          CTRL_TMR_A    = 3;
	localparam int          CTRL_TMR_B    = 4;
	localparam int          CTRL_SIO_EXT  = 5;
	localparam logic [5:0]  CTRL_RST      = 6'h04;

	// Status word fields
	localparam int          STAT_STATE_LSB = 0;
	localparam int          STAT_STATE_MSB = 2;
	localparam int          STAT_OSC       = 3;
	localparam int          STAT_CAUSE_LSB = 4;
	localparam int          STAT_CAUSE_MSB = 5;

	//////////////////////////////////////////////////////////////////////////
	// Stabilization time select codes
	localparam logic [2:0]  STAB_SEL_2P12 = 3'h0;
	localparam logic [2:0]  STAB_SEL_2P14 = 3'h1;
	localparam logic [2:0]  STAB_SEL_2P15 = 3'h2;
	localparam logic [2:0]  STAB_SEL_2P16 = 3'h3;
	localparam logic [2:0]  STAB_SEL_2P17 = 3'h4;

	// Resume delay after a halt wake, in clocks
	localparam logic [3:0]  RESUME_SVC_CYC = 4'h8;
	localparam logic [3:0]  RESUME_NXT_CYC = 4'h2;

	// Wake cause codes
	localparam logic [1:0]  CAUSE_NONE    = 2'h0;
	localparam logic [1:0]  CAUSE_SERVICE = 2'h1;
	localparam logic [1:0]  CAUSE_NEXT    = 2'h2;
	localparam logic [1:0]  CAUSE_RESET   = 2'h3;

	//////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [2:0] {
		ST_RUN,
		ST_HALT,
		ST_STOP,
		ST_STAB,
		ST_RESUME
	} swc_state_e;

	typedef struct packed {
		logic [IRQ_N-1:0] req;
		logic [IRQ_N-1:0] mask;
		logic [IRQ_N-1:0] prio;
		logic             ie;
		logic             in_service_priority_flag;
		logic             nmi;
	} swc_irq_s;

	typedef struct packed {
		logic timer16;
		logic timer8_a;
		logic timer8_b;
		logic watch;
		logic watchdog;
		logic adc;
		logic uart;
		logic csi;
		logic lcd;
		logic sound;
		logic meter;
		logic ext_int;
	} swc_periph_s;

	localparam swc_periph_s PERIPH_ALL_RUN = 12'hfff;

endpackage : swc_pkg
`default_nettype wire

/* File: verilog/swc_top.sv */
// Standby wake controller: halt/stop sequencing, wake decision, stabilization wait, AXI4-Lite registers
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module swc_top #(
	parameter int STAB_CNT_0 = 4096,
	parameter int STAB_CNT_1 = 16384,
	parameter int STAB_CNT_2 = 32768,
	parameter int STAB_CNT_3 = 65536,
	parameter int STAB_CNT_4 = 131072
) (
	// Clock and reset
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	// Core and interrupt controller
	input  wire logic                       halt_exec,
	input  wire logic                       stop_exec,
	input  wire logic                       reset_req,
	input  wire swc_pkg::swc_irq_s          irq_in,
	// Main oscillator
	input  wire logic                       osc_running,
	output var  logic                       osc_enable_q,
	output var  logic                       oscillator_output_pin_pullup_q,
	output var  logic                       subsys_clk_en_q,
	// Core control
	output var  logic                       core_clk_en_q,
	output var  logic                       core_reset_q,
	output var  logic                       wake_service_q,
	output var  logic                       wake_next_q,
	output var  logic                       port_latch_hold_q,
	output var  swc_pkg::swc_periph_s       periph_run_q,
	// AXI4-Lite slave
	input  wire logic [swc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output var  logic                       s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output var  logic                       s_axi_wready,
	output var  logic [1:0]                 s_axi_bresp,
	output var  logic                       s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [swc_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output var  logic                       s_axi_arready,
	output var  logic [31:0]                s_axi_rdata,
	output var  logic [1:0]                 s_axi_rresp,
	output var  logic                       s_axi_rvalid,
	input  wire logic                       s_axi_rready
);

	//////////////////////////////////////////////////////////////////////////
	// Declarations
	swc_pkg::swc_state_e                  state_q;
	swc_pkg::swc_state_e                  state_d;
	logic [5:0]                           ctrl_q;
	logic [1:0]                           cause_q;
	logic [1:0]                           cause_d;
	logic [swc_pkg::STAB_CNT_W-1:0]       stab_cnt_q;
	logic [swc_pkg::STAB_CNT_W-1:0]       stab_tgt_q;
	logic [3:0]                           resume_cnt_q;
	logic                                 pend_service_q;
	logic                                 pend_reset_q;
	logic                                 wake_any;
	logic                                 wake_svc;
	logic                                 stab_done;
	logic                                 resume_done;
	logic                                 aw_hold_q;
	logic                                 w_hold_q;
	logic [swc_pkg::ADDR_W-1:0]           awaddr_q;
	logic [31:0]                          wdata_q;
	logic [3:0]                           wstrb_q;
	logic                                 wr_fire;

	//////////////////////////////////////////////////////////////////////////
	// Functions
	// Any source with its mask flag cleared and its request raised
	function automatic logic unmasked_req(input swc_pkg::swc_irq_s f);
		unmasked_req = |(f.req & ~f.mask);
	endfunction : unmasked_req
	// High priority needs enable; low priority needs enable and in-service flag
	function automatic logic wants_service(input swc_pkg::swc_irq_s f);
		logic [swc_pkg::IRQ_N-1:0] hi;
		logic [swc_pkg::IRQ_N-1:0] lo;
		hi = f.req & ~f.mask & ~f.prio;
		lo = f.req & ~f.mask & f.prio;
		wants_service = f.ie & ((|hi) | ((|lo) & f.in_service_priority_flag));
	endfunction : wants_service
	// Wait length for a select code; prohibited codes never reach here
	function automatic logic [swc_pkg::STAB_CNT_W-1:0] stab_target(input logic [2:0] sel);
		case (sel)
			swc_pkg::STAB_SEL_2P12: stab_target = swc_pkg::STAB_CNT_W'(STAB_CNT_0 - 1);
			swc_pkg::STAB_SEL_2P14: stab_target = swc_pkg::STAB_CNT_W'(STAB_CNT_1 - 1);
			swc_pkg::STAB_SEL_2P15: stab_target = swc_pkg::STAB_CNT_W'(STAB_CNT_2 - 1);
			swc_pkg::STAB_SEL_2P16: stab_target = swc_pkg::STAB_CNT_W'(STAB_CNT_3 - 1);
			default:                stab_target = swc_pkg::STAB_CNT_W'(STAB_CNT_4 - 1);
		endcase
	endfunction : stab_target
	function automatic logic sel_legal(input logic [2:0] sel);
		sel_legal = (sel <= swc_pkg::STAB_SEL_2P17);
	endfunction : sel_legal

	//////////////////////////////////////////////////////////////////////////
	// Wake decision
	assign wake_any    = unmasked_req(irq_in);
	assign wake_svc    = wants_service(irq_in);
	assign stab_done   = osc_running && (stab_cnt_q == stab_tgt_q);
	assign resume_done = (resume_cnt_q == 4'h0);

	//////////////////////////////////////////////////////////////////////////
	// Mode sequencer
	always_comb begin
		state_d = state_q;
		cause_d = swc_pkg::CAUSE_NONE;
		case (state_q)
			swc_pkg::ST_RUN: begin
				if (stop_exec) begin
					// A pending unmasked request turns stop into halt plus the wait
					state_d = wake_any ? swc_pkg::ST_STAB : swc_pkg::ST_STOP;
				end else if (halt_exec) begin
					state_d = swc_pkg::ST_HALT;
				end
			end
			swc_pkg::ST_HALT: begin
				if (reset_req) begin
					state_d = swc_pkg::ST_RUN;
					cause_d = swc_pkg::CAUSE_RESET;
				end else if (irq_in.nmi || wake_any) begin
					state_d = swc_pkg::ST_RESUME;
				end
			end
			swc_pkg::ST_STOP: begin
				// No NMI path out of stop; masked sources keep it asleep
				if (reset_req || wake_any) begin
					state_d = swc_pkg::ST_STAB;
				end
			end
			swc_pkg::ST_STAB: begin
				if (stab_done) begin
					state_d = swc_pkg::ST_RUN;
					cause_d = pend_reset_q ? swc_pkg::CAUSE_RESET :
					          pend_service_q ? swc_pkg::CAUSE_SERVICE : swc_pkg::CAUSE_NEXT;
				end
			end
			swc_pkg::ST_RESUME: begin
				if (resume_done) begin
					state_d = swc_pkg::ST_RUN;
					cause_d = pend_service_q ? swc_pkg::CAUSE_SERVICE : swc_pkg::CAUSE_NEXT;
				end
			end
			default: state_d = swc_pkg::ST_RUN;
		endcase
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= swc_pkg::ST_RUN;
		end else begin
			state_q <= state_d;
		end
	end
	// Wake kind latched when the wake is decided, before the flags can move
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend_service_q <= 1'b0;
			pend_reset_q   <= 1'b0;
		end else if (state_q == swc_pkg::ST_HALT && state_d == swc_pkg::ST_RESUME) begin
			pend_service_q <= irq_in.nmi || wake_svc;
			pend_reset_q   <= 1'b0;
		end else if (state_d == swc_pkg::ST_STAB && state_q != swc_pkg::ST_STAB) begin
			pend_service_q <= wake_svc;
			pend_reset_q   <= reset_req && state_q == swc_pkg::ST_STOP;
		end else if (state_q == swc_pkg::ST_STAB && reset_req) begin
			pend_reset_q   <= 1'b1;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Stabilization counter
	// Counts only while the restarted oscillator is running, so start-up time is not included
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stab_cnt_q <= '0;
			stab_tgt_q <= '0;
		end else if (state_q != swc_pkg::ST_STAB) begin
			stab_cnt_q <= '0;
			// Reset wake from stop always waits the longest time
			stab_tgt_q <= (reset_req && state_q == swc_pkg::ST_STOP) ?
			              stab_target(swc_pkg::STAB_SEL_2P17) :
			              stab_target(ctrl_q[swc_pkg::CTRL_STAB_MSB:swc_pkg::CTRL_STAB_LSB]);
		end else if (osc_running && !stab_done) begin
			stab_cnt_q <= stab_cnt_q + 1'b1;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			resume_cnt_q <= '0;
		end else if (state_q == swc_pkg::ST_HALT) begin
			resume_cnt_q <= (irq_in.nmi || wake_svc) ? swc_pkg::RESUME_SVC_CYC - 4'h1 :
			                swc_pkg::RESUME_NXT_CYC - 4'h1;
		end else if (!resume_done) begin
			resume_cnt_q <= resume_cnt_q - 4'h1;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Clock, core and peripheral outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			core_clk_en_q                  <= 1'b1;
			osc_enable_q                   <= 1'b1;
			oscillator_output_pin_pullup_q <= 1'b0;
			subsys_clk_en_q                <= 1'b1;
			port_latch_hold_q              <= 1'b0;
		end else begin
			// Gating the core clock freezes its registers and memory as they stand
			core_clk_en_q                  <= (state_d == swc_pkg::ST_RUN);
			osc_enable_q                   <= (state_d != swc_pkg::ST_STOP);
			oscillator_output_pin_pullup_q <= (state_d == swc_pkg::ST_STOP);
			subsys_clk_en_q                <= 1'b1;
			port_latch_hold_q              <= (state_d != swc_pkg::ST_RUN);
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			periph_run_q <= swc_pkg::PERIPH_ALL_RUN;
		end else if (state_d == swc_pkg::ST_STOP) begin
			periph_run_q          <= '0;
			periph_run_q.ext_int  <= 1'b1;
			periph_run_q.timer8_a <= ctrl_q[swc_pkg::CTRL_TMR_A];
			periph_run_q.timer8_b <= ctrl_q[swc_pkg::CTRL_TMR_B];
			periph_run_q.csi      <= ctrl_q[swc_pkg::CTRL_SIO_EXT];
		end else begin
			periph_run_q     <= swc_pkg::PERIPH_ALL_RUN;
			// Converter also idles in halt to save power
			periph_run_q.adc <= (state_d == swc_pkg::ST_RUN);
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			core_reset_q   <= 1'b0;
			wake_service_q <= 1'b0;
			wake_next_q    <= 1'b0;
			cause_q        <= swc_pkg::CAUSE_NONE;
		end else begin
			core_reset_q   <= (cause_d == swc_pkg::CAUSE_RESET);
			wake_service_q <= (cause_d == swc_pkg::CAUSE_SERVICE);
			wake_next_q    <= (cause_d == swc_pkg::CAUSE_NEXT);
			if (cause_d != swc_pkg::CAUSE_NONE) begin
				cause_q <= cause_d;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write path
	assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q     <= 1'b0;
			awaddr_q      <= '0;
			s_axi_awready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_hold_q <= 1'b0;
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_hold_q     <= 1'b0;
			wdata_q      <= '0;
			wstrb_q      <= '0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_wready <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_hold_q <= 1'b0;
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= swc_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (awaddr_q == swc_pkg::ADDR_CTRL || awaddr_q == swc_pkg::ADDR_STATUS) ?
			                swc_pkg::RESP_OKAY : swc_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
	// A prohibited select code leaves the previous selection in place
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= swc_pkg::CTRL_RST;
		end else if (wr_fire && awaddr_q == swc_pkg::ADDR_CTRL && wstrb_q[0]) begin
			ctrl_q[swc_pkg::CTRL_SIO_EXT:swc_pkg::CTRL_TMR_A] <= wdata_q[swc_pkg::CTRL_SIO_EXT:swc_pkg::CTRL_TMR_A];
			if (sel_legal(wdata_q[swc_pkg::CTRL_STAB_MSB:swc_pkg::CTRL_STAB_LSB])) begin
				ctrl_q[swc_pkg::CTRL_STAB_MSB:swc_pkg::CTRL_STAB_LSB] <=
					wdata_q[swc_pkg::CTRL_STAB_MSB:swc_pkg::CTRL_STAB_LSB];
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read path
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= swc_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= '0;
				s_axi_rresp  <= swc_pkg::RESP_OKAY;
				case (s_axi_araddr)
					swc_pkg::ADDR_CTRL: begin
						s_axi_rdata[5:0] <= ctrl_q;
					end
					swc_pkg::ADDR_STATUS: begin
						s_axi_rdata[swc_pkg::STAT_STATE_MSB:swc_pkg::STAT_STATE_LSB] <= state_q;
						s_axi_rdata[swc_pkg::STAT_OSC]                               <= osc_running;
						s_axi_rdata[swc_pkg::STAT_CAUSE_MSB:swc_pkg::STAT_CAUSE_LSB] <= cause_q;
					end
					default: begin
						s_axi_rresp <= swc_pkg::RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule : swc_top
`default_nettype wire
